// >>> afm_pkg.sv
// Package for the ARP/RARP access-control-entry matcher.
// Assumes one AHB-Lite slave port and a parser that supplies decoded ARP fields.
package afm_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] AFM_CTRL_OFS      = 8'h00;
  localparam logic [7:0] AFM_SPA_ADDR_OFS  = 8'h04;
  localparam logic [7:0] AFM_SPA_MASK_OFS  = 8'h08;
  localparam logic [7:0] AFM_TPA_ADDR_OFS  = 8'h0C;
  localparam logic [7:0] AFM_TPA_MASK_OFS  = 8'h10;
  localparam logic [7:0] AFM_STATUS_OFS    = 8'h14;

  // ---------------------------------------------------------------------------
  // Control register field positions (two bits each)
  // ---------------------------------------------------------------------------
  localparam int AFM_OPCLS_POS  = 0;
  localparam int AFM_DIR_POS    = 2;
  localparam int AFM_SPA_POS    = 4;
  localparam int AFM_TPA_POS    = 6;
  localparam int AFM_SHW_POS    = 8;
  localparam int AFM_THW_POS    = 10;
  localparam int AFM_LEN_POS    = 12;
  localparam int AFM_HSP_POS    = 14;
  localparam int AFM_PSP_POS    = 16;
  localparam int AFM_CTRL_BITS  = 18;

  // Control reset value: class, direction and address filters don't-care; three-way checks demand each condition absent.
  localparam logic [31:0] AFM_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] AFM_ADDR_RST  = 32'h0000_0000;
  localparam logic [31:0] AFM_MASK_RST  = 32'hFFFF_FFFF;

  // ---------------------------------------------------------------------------
  // Setting encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] AFM_OPCLS_ANY   = 2'h0;
  localparam logic [1:0] AFM_OPCLS_ARP   = 2'h1;
  localparam logic [1:0] AFM_OPCLS_RARP  = 2'h2;
  localparam logic [1:0] AFM_OPCLS_OTHER = 2'h3;

  localparam logic [1:0] AFM_DIR_ANY     = 2'h0;
  localparam logic [1:0] AFM_DIR_REQ     = 2'h1;
  localparam logic [1:0] AFM_DIR_REPLY   = 2'h2;

  localparam logic [1:0] AFM_IPF_ANY     = 2'h0;
  localparam logic [1:0] AFM_IPF_HOST    = 2'h1;
  localparam logic [1:0] AFM_IPF_NET     = 2'h2;

  // Three-way checks: value 0, value 1, don't-care (2 or 3).
  localparam logic [1:0] AFM_TRI_ZERO    = 2'h0;
  localparam logic [1:0] AFM_TRI_ONE     = 2'h1;

  // ---------------------------------------------------------------------------
  // Protocol constants
  // ---------------------------------------------------------------------------
  localparam logic [15:0] AFM_OP_ARP_REQ    = 16'h0001;
  localparam logic [15:0] AFM_OP_ARP_REPLY  = 16'h0002;
  localparam logic [15:0] AFM_OP_RARP_REQ   = 16'h0003;
  localparam logic [15:0] AFM_OP_RARP_REPLY = 16'h0004;
  localparam logic [7:0]  AFM_HW_LEN_ETH    = 8'h06;
  localparam logic [7:0]  AFM_PROTO_LEN_IP4 = 8'h04;
  localparam logic [15:0] AFM_HW_SPACE_ETH  = 16'h0001;
  localparam logic [15:0] AFM_PROTO_SPACE_IP = 16'h0800;

  localparam logic [1:0] AFM_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] AFM_HSIZE_WORD    = 3'h2;

endpackage

// >>> afm_arp_matcher.sv
// ARP/RARP matcher for one access-control entry, with its settings in AHB-Lite registers.
// Assumes the parser presents one decoded frame per cycle with frame_valid, in the hclk domain.
//
// Overview of operation
// - Opcode class offers any, ARP, RARP, other; ARP/RARP need that protocol's opcode.
// - Class other matches only opcodes that are neither known ARP nor RARP values.
// - Request setting needs an ARP request or RARP request opcode.
// - Reply setting needs an ARP or RARP reply; don't-care ignores direction.
// - Sender address filter: any, host, network; host compares all 32 bits exactly.
// - Network mode masks frame sender address and configured address, then compares.
// - Target address filter has the same any, host and network modes.
// - Sender hardware check: 1 needs equality with source MAC, 0 needs difference.
// - Target hardware check: 1 needs equality with source MAC, 0 needs difference.
// - Length check tests hardware length 0x06 and protocol length 0x04.
// - Hardware-space check tests hardware type field equal to 1.
// - Protocol-space check tests protocol type field equal to 0x800.
`timescale 1ns/1ps

module afm_arp_matcher (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        frame_valid,
  input  wire logic        frame_is_arp,
  input  wire logic [15:0] arp_opcode,
  input  wire logic [15:0] hardware_space_field,
  input  wire logic [15:0] protocol_space_field,
  input  wire logic [7:0]  hw_addr_len,
  input  wire logic [7:0]  proto_addr_len,
  input  wire logic [47:0] sender_hw_addr,
  input  wire logic [31:0] sender_protocol_address,
  input  wire logic [47:0] target_hw_addr,
  input  wire logic [31:0] target_protocol_address,
  input  wire logic [47:0] frame_source_mac,
  output logic             match_valid,
  output logic             match_hit
);
  import afm_pkg::*;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  // The slave never inserts wait states and always answers OKAY, so every
  // access completes in the cycle after its address phase.
  logic [31:0] ctrl_ff;
  logic [31:0] spa_addr_ff;
  logic [31:0] spa_mask_ff;
  logic [31:0] tpa_addr_ff;
  logic [31:0] tpa_mask_ff;
  logic [31:0] hit_count_ff;
  logic        last_hit_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] nxt_hrdata;
  logic        addr_ok;
  logic        fwd_hit;
  logic [31:0] fwd_data;

  assign addr_ok = hsel && hready && (htrans == AFM_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff     <= AFM_CTRL_RST;
      spa_addr_ff <= AFM_ADDR_RST;
      spa_mask_ff <= AFM_MASK_RST;
      tpa_addr_ff <= AFM_ADDR_RST;
      tpa_mask_ff <= AFM_MASK_RST;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        AFM_CTRL_OFS: begin
          ctrl_ff <= {{(32 - AFM_CTRL_BITS){1'b0}}, hwdata[AFM_CTRL_BITS-1:0]};
        end
        AFM_SPA_ADDR_OFS: spa_addr_ff <= hwdata;
        AFM_SPA_MASK_OFS: spa_mask_ff <= hwdata;
        AFM_TPA_ADDR_OFS: tpa_addr_ff <= hwdata;
        AFM_TPA_MASK_OFS: tpa_mask_ff <= hwdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (haddr[7:0])
      AFM_CTRL_OFS:     nxt_hrdata = ctrl_ff;
      AFM_SPA_ADDR_OFS: nxt_hrdata = spa_addr_ff;
      AFM_SPA_MASK_OFS: nxt_hrdata = spa_mask_ff;
      AFM_TPA_ADDR_OFS: nxt_hrdata = tpa_addr_ff;
      AFM_TPA_MASK_OFS: nxt_hrdata = tpa_mask_ff;
      AFM_STATUS_OFS:   nxt_hrdata = {hit_count_ff[30:0], last_hit_ff};
      default:          nxt_hrdata = 32'h0000_0000;
    endcase
  end

  // A pipelined read may sample a word in the very data phase that writes it.
  // The register only takes the new value at that edge, so the read is fed from the bus.
  assign fwd_hit = wr_pend_ff && (wr_addr_ff == haddr[7:0]);

  always_comb begin
    case (wr_addr_ff)
      AFM_CTRL_OFS: begin
        fwd_data = {{(32 - AFM_CTRL_BITS){1'b0}}, hwdata[AFM_CTRL_BITS-1:0]};
      end
      AFM_SPA_ADDR_OFS: fwd_data = hwdata;
      AFM_SPA_MASK_OFS: fwd_data = hwdata;
      AFM_TPA_ADDR_OFS: fwd_data = hwdata;
      AFM_TPA_MASK_OFS: fwd_data = hwdata;
      default:          fwd_data = nxt_hrdata;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= fwd_hit ? fwd_data : nxt_hrdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Criteria
  // ---------------------------------------------------------------------------
  logic [1:0] opcls;
  logic [1:0] dir_sel;
  logic [1:0] spa_sel;
  logic [1:0] tpa_sel;
  logic [1:0] tri_sel [5];
  logic [4:0] tri_cond;
  logic [4:0] tri_ok;
  logic       op_arp;
  logic       op_rarp;
  logic       op_req;
  logic       op_reply;
  logic       opcls_ok;
  logic       dir_ok;
  logic       spa_ok;
  logic       tpa_ok;
  logic       nxt_hit;

  assign opcls   = ctrl_ff[AFM_OPCLS_POS +: 2];
  assign dir_sel = ctrl_ff[AFM_DIR_POS +: 2];
  assign spa_sel = ctrl_ff[AFM_SPA_POS +: 2];
  assign tpa_sel = ctrl_ff[AFM_TPA_POS +: 2];
  assign tri_sel[0] = ctrl_ff[AFM_SHW_POS +: 2];
  assign tri_sel[1] = ctrl_ff[AFM_THW_POS +: 2];
  assign tri_sel[2] = ctrl_ff[AFM_LEN_POS +: 2];
  assign tri_sel[3] = ctrl_ff[AFM_HSP_POS +: 2];
  assign tri_sel[4] = ctrl_ff[AFM_PSP_POS +: 2];

  assign op_req   = (arp_opcode == AFM_OP_ARP_REQ) || (arp_opcode == AFM_OP_RARP_REQ);
  assign op_reply = (arp_opcode == AFM_OP_ARP_REPLY) || (arp_opcode == AFM_OP_RARP_REPLY);
  assign op_arp   = (arp_opcode == AFM_OP_ARP_REQ) || (arp_opcode == AFM_OP_ARP_REPLY);
  assign op_rarp  = (arp_opcode == AFM_OP_RARP_REQ) || (arp_opcode == AFM_OP_RARP_REPLY);

  always_comb begin
    case (opcls)
      AFM_OPCLS_ARP:   opcls_ok = op_arp;
      AFM_OPCLS_RARP:  opcls_ok = op_rarp;
      AFM_OPCLS_OTHER: opcls_ok = !op_arp && !op_rarp;
      default:         opcls_ok = 1'b1;
    endcase
  end

  always_comb begin
    case (dir_sel)
      AFM_DIR_REQ:   dir_ok = op_req;
      AFM_DIR_REPLY: dir_ok = op_reply;
      default:       dir_ok = 1'b1;
    endcase
  end

  always_comb begin
    case (spa_sel)
      AFM_IPF_HOST: spa_ok = (sender_protocol_address == spa_addr_ff);
      AFM_IPF_NET: begin
        spa_ok = ((sender_protocol_address & spa_mask_ff) ==
                  (spa_addr_ff & spa_mask_ff));
      end
      default:      spa_ok = 1'b1;
    endcase
  end

  always_comb begin
    case (tpa_sel)
      AFM_IPF_HOST: tpa_ok = (target_protocol_address == tpa_addr_ff);
      AFM_IPF_NET: begin
        tpa_ok = ((target_protocol_address & tpa_mask_ff) ==
                  (tpa_addr_ff & tpa_mask_ff));
      end
      default:      tpa_ok = 1'b1;
    endcase
  end

  assign tri_cond[0] = (sender_hw_addr == frame_source_mac);
  assign tri_cond[1] = (target_hw_addr == frame_source_mac);
  assign tri_cond[2] = (hw_addr_len == AFM_HW_LEN_ETH) &&
                       (proto_addr_len == AFM_PROTO_LEN_IP4);
  assign tri_cond[3] = (hardware_space_field == AFM_HW_SPACE_ETH);
  assign tri_cond[4] = (protocol_space_field == AFM_PROTO_SPACE_IP);

  // Each three-way check: 1 demands the condition, 0 demands its absence.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_tri
      assign tri_ok[gi] = (tri_sel[gi] == AFM_TRI_ONE)  ?  tri_cond[gi] :
                          (tri_sel[gi] == AFM_TRI_ZERO) ? !tri_cond[gi] : 1'b1;
    end
  endgenerate

  // Non-ARP frames never hit, even with every criterion set to don't-care.
  assign nxt_hit = frame_is_arp &&
                   opcls_ok && dir_ok && spa_ok && tpa_ok && (&tri_ok);

  // ---------------------------------------------------------------------------
  // Result and status
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_valid <= 1'b0;
      match_hit   <= 1'b0;
    end else begin
      match_valid <= frame_valid;
      match_hit   <= frame_valid && nxt_hit;
    end
  end

  // Hit counter wraps silently; software samples differences.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_count_ff <= 32'h0000_0000;
      last_hit_ff  <= 1'b0;
    end else if (frame_valid) begin
      last_hit_ff <= nxt_hit;
      if (nxt_hit) begin
        hit_count_ff <= hit_count_ff + 32'h0000_0001;
      end
    end
  end

endmodule

// >>> afm_arp_matcher_asserts.sv
// Port checker for the ARP matcher: frame answer timing and bus answers.
// Assumes it is bound to the matcher top and sees one clock domain.
`timescale 1ns/1ps
module afm_arp_matcher_chk
  import afm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        frame_valid,
  input wire logic        frame_is_arp,
  input wire logic        match_valid,
  input wire logic        match_hit
);
  logic rd_req;
  assign rd_req = hsel && hready && htrans == AFM_HTRANS_NONSEQ && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_two;  frame_valid ##1 frame_valid; endsequence
  sequence s_ans2; match_valid ##1 match_valid; endsequence
  property p_answer; frame_valid |=> match_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("frame not answered after one cycle");
  property p_pair; s_two |-> s_ans2; endproperty
  a_pair: assert property (p_pair)
    else $error("back-to-back frames not both answered");
  property p_idle; !frame_valid |=> !match_valid && !match_hit; endproperty
  a_idle: assert property (p_idle) else $error("match report without a frame");
  property p_non_arp; frame_valid && !frame_is_arp |=> !match_hit; endproperty
  a_non_arp: assert property (p_non_arp) else $error("non-ARP frame hit");
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_hold; !rd_req |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");
  property p_unmapped;
    rd_req && haddr[31:5] == 27'h0 && haddr[4:2] > 3'h5 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind afm_arp_matcher afm_arp_matcher_chk i_chk (.*);

// >>> afm_parser_model.sv
// Stand-in for the ingress parser: one decoded frame per cycle that req is high.
// Assumes req changes just after rising hclk edges.
`timescale 1ns/1ps
module afm_parser_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        req,
  input  wire logic [31:0] spa_base,
  input  wire logic [31:0] tpa_base,
  output logic             frame_valid,
  output logic             frame_is_arp,
  output logic      [15:0] arp_opcode,
  output logic      [15:0] hardware_space_field,
  output logic      [15:0] protocol_space_field,
  output logic      [7:0]  hw_addr_len,
  output logic      [7:0]  proto_addr_len,
  output logic      [47:0] sender_hw_addr,
  output logic      [31:0] sender_protocol_address,
  output logic      [47:0] target_hw_addr,
  output logic      [31:0] target_protocol_address,
  output logic      [47:0] frame_source_mac
);
  logic [272:0] fields_ff;
  logic [47:0]  mac_ff;

  function automatic bit coin();
    return 1'($urandom % 2);
  endfunction

  // Each field except the ARP flag, opcode and source MAC is right or wrong by a coin toss, so every check sees both outcomes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_valid <= 1'b0;
      fields_ff <= '0;
      mac_ff <= '0;
    end else begin
      mac_ff <= 48'({$urandom(), $urandom()});
      frame_valid <= req;
      if (req) begin
        fields_ff <= {$urandom % 4 != 0, 16'($urandom % 6),
          coin() ? 16'h0001 : 16'h0006, coin() ? 16'h0800 : 16'h86DD,
          coin() ? 8'h06 : 8'h08, coin() ? 8'h04 : 8'h10,
          coin() ? mac_ff : ~mac_ff, spa_base ^ 32'(coin() ? 0 : $urandom % 256),
          coin() ? mac_ff : ~mac_ff, tpa_base ^ 32'(coin() ? 0 : $urandom % 256), mac_ff};
      end else begin
        // Between frames the lines invert every cycle, so the stale fields return on every second idle cycle.
        fields_ff <= ~fields_ff;
      end
    end
  end

  assign {frame_is_arp, arp_opcode, hardware_space_field, protocol_space_field, hw_addr_len,
          proto_addr_len, sender_hw_addr, sender_protocol_address, target_hw_addr,
          target_protocol_address, frame_source_mac} = fields_ff;
endmodule

// >>> tb.sv
// Self-checking bench for the ARP matcher: random entries over AHB-Lite, random frames.
// Assumes the parser model and the bound checker are compiled with it.
`timescale 1ns/1ps
module tb;
  import afm_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, req, hit, last_hit;
  logic        frame_valid, frame_is_arp, match_valid, match_hit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  hw_addr_len, proto_addr_len;
  logic [15:0] arp_opcode, hardware_space_field, protocol_space_field;
  logic [31:0] haddr, hwdata, hrdata, r, spa_base, tpa_base;
  logic [31:0] sender_protocol_address, target_protocol_address, cfg [5];
  logic [47:0] sender_hw_addr, target_hw_addr, frame_source_mac;
  bit          exp_q [$];
  int          n_fail, n_compared, n_hits, i;

  assign hready = hreadyout;
  afm_arp_matcher i_dut (.*);
  afm_parser_model i_parser (.*);

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  function automatic bit tri_ok(logic [1:0] s, bit c);
    return s == 2'h0 ? !c : s == 2'h1 ? c : 1'b1;
  endfunction
  function automatic bit ip_ok(logic [1:0] s, logic [31:0] a, logic [31:0] c, logic [31:0] m);
    return s == 2'h1 ? a == c : s == 2'h2 ? (a & m) == (c & m) : 1'b1;
  endfunction
  function automatic bit expect_hit();
    int op;
    bit arp;
    bit rarp;
    bit ok;
    op = arp_opcode;
    arp = op == 1 || op == 2;
    rarp = op == 3 || op == 4;
    ok = frame_is_arp;
    ok &= cfg[0][1:0] == 2'h1 ? arp : cfg[0][1:0] == 2'h2 ? rarp :
          cfg[0][1:0] == 2'h3 ? !(arp || rarp) : 1'b1;
    ok &= cfg[0][3:2] == 2'h1 ? op == 1 || op == 3 :
          cfg[0][3:2] == 2'h2 ? op == 2 || op == 4 : 1'b1;
    ok &= ip_ok(cfg[0][5:4], sender_protocol_address, cfg[1], cfg[2]);
    ok &= ip_ok(cfg[0][7:6], target_protocol_address, cfg[3], cfg[4]);
    ok &= tri_ok(cfg[0][9:8], sender_hw_addr == frame_source_mac);
    ok &= tri_ok(cfg[0][11:10], target_hw_addr == frame_source_mac);
    ok &= tri_ok(cfg[0][13:12], hw_addr_len == 8'h06 && proto_addr_len == 8'h04);
    ok &= tri_ok(cfg[0][15:14], hardware_space_field == 16'h0001);
    ok &= tri_ok(cfg[0][17:16], protocol_space_field == 16'h0800);
    return ok;
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ahb(bit w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= AFM_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Scoreboard: one expectation per frame, retired by the matching report.
  always @(posedge hclk) begin
    if (hresetn && match_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected match_valid", 32'h0, 32'h1);
      else chk("match_hit", exp_q.pop_front(), match_hit);
    end
    if (hresetn && frame_valid === 1'b1) begin
      hit = expect_hit();
      exp_q.push_back(hit);
      n_hits += hit;
      last_hit = hit;
    end
  end

  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h9650));
    {hresetn, hsel, hwrite, req, last_hit} = '0;
    {haddr, hwdata, spa_base, tpa_base, htrans} = '0;
    hsize = AFM_HSIZE_WORD;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 6; i++) begin
      ahb(0, 4 * i, 0);
      chk("reset value", (i == 2 || i == 4) ? 32'hFFFF_FFFF : 32'h0, r);
    end
    ahb(1, 32'h18, 32'hFFFF_FFFF);
    ahb(1, 32'h14, 32'hFFFF_FFFF);
    ahb(0, 32'h18, 0);
    chk("unmapped read", 32'h0, r);
    ahb(0, 32'h14, 0);
    chk("status after write", 32'h0, r);
    repeat (200) begin
      cfg[0] = $urandom & 32'h3FFFF;
      for (i = 1; i < 5; i++) cfg[i] = $urandom;
      for (i = 0; i < 5; i++) ahb(1, 4 * i, cfg[i]);
      i = $urandom % 5;
      ahb(0, 4 * i, 0);
      chk("register readback", cfg[i], r);
      spa_base <= cfg[1];
      tpa_base <= cfg[3];
      req <= 1'b1;
      repeat (1 + $urandom % 3) @(posedge hclk);
      req <= 1'b0;
      repeat (3) @(posedge hclk);
      ahb(0, 32'h14, 0);
      chk("status", {n_hits[30:0], last_hit}, r);
    end
    chk("pending frames", 32'h0, exp_q.size());
    end_of_test();
  end
endmodule
